// file: hdl/lpbr_pkg.sv
// Shared constants of the lamp poll bus responder.
package lpbr_pkg;
  // ****************************************
  // Clocking and line timing
  // ****************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int BAUD = 38_400;
  localparam int BIT_CYC = CLK_HZ / BAUD;
  localparam int GAP_TIME_US = 1000;
  localparam int GAP_CYC = GAP_TIME_US * (CLK_HZ / 1_000_000);
  localparam int RATE_HOLD_MS = 100;
  localparam int RATE_HOLD_CYC = RATE_HOLD_MS * (CLK_HZ / 1000);
  // ****************************************
  // Bus words and addresses
  // ****************************************
  localparam int MAX_RX_BYTES = 10;
  localparam int RESP_BYTES = 6;
  localparam int ADDR_FLAG_BIT = 8;
  localparam logic [7:0] LAMP_ADDR_BASE = 8'h10;
  localparam logic [7:0] PANEL_ADDR_TOP = 8'h0F;
  localparam logic [5:0] SW_MAX = 6'h28;
  localparam logic [11:0] POS_CENTRE = 12'h800;
  // ****************************************
  // Panel commands
  // ****************************************
  localparam logic [7:0] CMD_PAN_RATE = 8'h01;
  localparam logic [7:0] CMD_TILT_RATE = 8'h02;
  localparam logic [7:0] CMD_LAMP_TOGGLE = 8'h0A;
  localparam logic [7:0] CMD_RECORD = 8'h0D;
  localparam logic [7:0] CMD_PLAY = 8'h0E;
  localparam logic [7:0] CMD_STORE_HOME = 8'h0F;
  localparam logic [7:0] CMD_PAN_TARGET = 8'h18;
  localparam logic [7:0] CMD_TILT_TARGET = 8'h19;
  // ****************************************
  // Registers and fields
  // ****************************************
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_POS = 12'h004;
  localparam logic [11:0] REG_SENSE = 12'h008;
  localparam logic [11:0] REG_STATUS = 12'h00C;
  localparam logic [11:0] REG_TARGET = 12'h010;
  localparam logic [11:0] REG_HOME = 12'h014;
  localparam logic [11:0] REG_RATE = 12'h018;
  localparam logic [11:0] REG_ERR = 12'h01C;
  localparam int HI_LSB = 16;
  localparam int STATE_LSB = 8;
  localparam int SN_PAN_LIM = 0;
  localparam int SN_TILT_LIM = 1;
  localparam int SN_OVERHEAT = 2;
  localparam int SN_HOMING = 3;
  localparam logic [5:0] CTRL_RST = 6'h00;
endpackage

// file: hdl/lpbr_word_if.sv
// Nine-bit word carrier between the responder and its serial units.
`timescale 1ns/1ps
interface lpbr_word_if;
  logic [8:0] rx_word;
  logic rx_valid;
  logic [8:0] tx_word;
  logic tx_valid;
  logic tx_ready;
  logic tx_busy;
  modport rx (output rx_word, output rx_valid);
  modport tx (input tx_word, input tx_valid, output tx_ready, output tx_busy);
  modport core (input rx_word, input rx_valid, output tx_word, output tx_valid, input tx_ready, input tx_busy);
endinterface

// file: hdl/lpbr_uart_rx.sv
// Receiver for eleven-bit characters of the searchlight poll bus.
`timescale 1ns/1ps
module lpbr_uart_rx #(
  parameter int BIT_CYCLES = lpbr_pkg::BIT_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bus_rx,
  lpbr_word_if.rx w
);
  localparam logic [10:0] FULL = 11'(BIT_CYCLES - 1);
  localparam logic [10:0] HALF = 11'(BIT_CYCLES / 2);
  typedef struct packed {
    logic busy;
    logic [3:0] bitn;
    logic [10:0] cnt;
    logic [8:0] sh;
    logic [8:0] word;
    logic valid;
  } lpbr_rx_t;
  lpbr_rx_t cur_ff;
  lpbr_rx_t nxt_cur;

  if (BIT_CYCLES < 4 || BIT_CYCLES > 2047)
  begin : g_chk
    $error("Bit period does not fit the counter.");
  end

  // Sampling in mid bit; a start bit that is gone at mid bit is a glitch.
  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.valid = 1'b0;
    if (!cur_ff.busy)
    begin
      if (!bus_rx)
      begin
        nxt_cur.busy = 1'b1;
        nxt_cur.bitn = 4'h0;
        nxt_cur.cnt = HALF;
      end
    end
    else if (cur_ff.cnt != 11'h000)
      nxt_cur.cnt = cur_ff.cnt - 11'h001;
    else
    begin
      nxt_cur.cnt = FULL;
      nxt_cur.bitn = cur_ff.bitn + 4'h1;
      if (cur_ff.bitn == 4'h0)
        nxt_cur.busy = !bus_rx;
      else if (cur_ff.bitn < 4'hA)
        nxt_cur.sh = {bus_rx, cur_ff.sh[8:1]};
      else
      begin
        nxt_cur.busy = 1'b0;
        nxt_cur.word = cur_ff.sh;
        nxt_cur.valid = bus_rx;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur_ff <= '0;
    else
      cur_ff <= nxt_cur;
  end

  assign w.rx_word = cur_ff.word;
  assign w.rx_valid = cur_ff.valid;

  a_rx_stop_ok: assert property (@(posedge pclk) disable iff (!presetn)
    cur_ff.valid |-> $past(cur_ff.bitn) == 4'hA && $past(bus_rx))
    else $error("Word delivered without a valid stop bit.");
endmodule

// file: hdl/lpbr_uart_tx.sv
// Transmitter for eleven-bit characters with driver enable control.
`timescale 1ns/1ps
module lpbr_uart_tx #(
  parameter int BIT_CYCLES = lpbr_pkg::BIT_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  lpbr_word_if.tx w,
  output logic bus_tx,
  output logic bus_de
);
  localparam logic [10:0] FULL = 11'(BIT_CYCLES - 1);

  if (BIT_CYCLES < 4 || BIT_CYCLES > 2047)
  begin : g_chk
    $error("Bit period does not fit the counter.");
  end
  typedef struct packed {
    logic busy;
    logic de;
    logic line;
    logic [3:0] bitn;
    logic [10:0] cnt;
    logic [9:0] sh;
  } lpbr_tx_t;
  lpbr_tx_t cur_ff;
  lpbr_tx_t nxt_cur;

  // The driver stays enabled between bytes of one answer so the line never floats mid answer.
  always_comb
  begin
    nxt_cur = cur_ff;
    if (!cur_ff.busy)
    begin
      nxt_cur.de = w.tx_valid;
      if (w.tx_valid)
      begin
        nxt_cur.busy = 1'b1;
        nxt_cur.line = 1'b0;
        nxt_cur.sh = {1'b1, w.tx_word};
        nxt_cur.bitn = 4'h0;
        nxt_cur.cnt = FULL;
      end
    end
    else if (cur_ff.cnt != 11'h000)
      nxt_cur.cnt = cur_ff.cnt - 11'h001;
    else if (cur_ff.bitn == 4'hA)
    begin
      nxt_cur.busy = 1'b0;
      nxt_cur.line = 1'b1;
    end
    else
    begin
      nxt_cur.cnt = FULL;
      nxt_cur.bitn = cur_ff.bitn + 4'h1;
      nxt_cur.line = cur_ff.sh[0];
      nxt_cur.sh = {1'b1, cur_ff.sh[9:1]};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur_ff <= '{busy: 1'b0, de: 1'b0, line: 1'b1, bitn: 4'h0, cnt: 11'h000, sh: 10'h3FF};
    else
      cur_ff <= nxt_cur;
  end

  assign w.tx_ready = !cur_ff.busy;
  assign w.tx_busy = cur_ff.busy;
  assign bus_tx = cur_ff.line;
  assign bus_de = cur_ff.de;

  a_tx_start_bit: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cur_ff.busy) |-> !bus_tx && bus_de ##1 !bus_tx [*8])
    else $error("Start bit not driven low.");
endmodule

// file: hdl/lpbr_responder.sv
// Lamp poll bus responder: command decoding, poll answer and APB registers.
`timescale 1ns/1ps
module lpbr_responder #(
  parameter int GAP_CYCLES = lpbr_pkg::GAP_CYC,
  parameter int RATE_HOLD_CYCLES = lpbr_pkg::RATE_HOLD_CYC,
  parameter int BIT_CYCLES = lpbr_pkg::BIT_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_rx,
  output logic bus_tx,
  output logic bus_de
);
  localparam logic [19:0] GAP_LIM = 20'(GAP_CYCLES - 1);
  localparam logic [22:0] HOLD = 23'(RATE_HOLD_CYCLES);
  localparam logic [3:0] RX_BUF = 4'(lpbr_pkg::MAX_RX_BYTES - 1);
  localparam logic [2:0] RESP_LAST = 3'(lpbr_pkg::RESP_BYTES - 1);

  if (GAP_CYCLES < 2 || GAP_CYCLES > 1048575)
  begin : g_chk_gap
    $error("GAP_CYCLES does not fit the gap counter.");
  end
  // A frame ends on silence, so the silence limit must outlast one character and its spacing.
  if (GAP_CYCLES <= 12 * BIT_CYCLES)
  begin : g_chk_char
    $error("GAP_CYCLES is shorter than one character time.");
  end
  if (RATE_HOLD_CYCLES < 1 || RATE_HOLD_CYCLES > 8388607)
  begin : g_chk_hold
    $error("RATE_HOLD_CYCLES does not fit the hold counter.");
  end

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_SLOT = 5'h02,
    S_COLLECT = 5'h04,
    S_EXEC = 5'h08,
    S_RESP = 5'h10
  } lpbr_state_t;

  // The buffer has sixteen slots so parameter look-ahead never indexes outside it.
  typedef struct packed {
    lpbr_state_t state;
    logic [19:0] gap;
    logic [3:0] cnt;
    logic [15:0][7:0] rxb;
    logic [7:0] total;
    logic ovf;
    logic [3:0] idx;
    logic pend;
    logic [8:0] pend_word;
    logic [2:0] tx_idx;
    logic [5:0][7:0] resp;
    logic [5:0] sw;
    logic [11:0] pos_pan;
    logic [11:0] pos_tilt;
    logic [3:0] sense;
    logic lamp_on;
    logic rec;
    logic play;
    logic [11:0] tgt_pan;
    logic [11:0] tgt_tilt;
    logic [11:0] home_pan;
    logic [11:0] home_tilt;
    logic [7:0] pan_rate;
    logic [7:0] tilt_rate;
    logic pan_act;
    logic tilt_act;
    logic [22:0] hold;
    logic [7:0] err_cnt;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } lpbr_core_t;

  lpbr_core_t cur_ff;
  lpbr_core_t nxt_cur;
  lpbr_word_if wif ();

  lpbr_uart_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .bus_rx(bus_rx),
    .w(wif.rx)
  );

  lpbr_uart_tx #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .w(wif.tx),
    .bus_tx(bus_tx),
    .bus_de(bus_de)
  );

  // ****************************************
  // Decode helpers
  // ****************************************
  logic [7:0] own;
  logic in_valid;
  logic [8:0] in_word;
  logic is_addr;
  logic is_panel;
  logic gap_out;
  logic [7:0] last;
  logic [3:0] body;
  logic frame_ok;
  logic end_frame;
  logic exec_step;
  logic [7:0] cmd;
  logic [7:0] p1;
  logic [11:0] p_word;
  logic [7:0] st_byte;
  logic [31:0] rd;
  logic hit;
  logic [3:0] len;

  assign own = 8'(lpbr_pkg::LAMP_ADDR_BASE + {2'b00, cur_ff.sw});
  // Our own echo is ignored while the transmitter is busy.
  assign in_valid = cur_ff.pend | (wif.rx_valid & !wif.tx_busy);
  assign in_word = cur_ff.pend ? cur_ff.pend_word : wif.rx_word;
  assign is_addr = in_word[lpbr_pkg::ADDR_FLAG_BIT];
  assign is_panel = is_addr && in_word[7:0] <= lpbr_pkg::PANEL_ADDR_TOP;
  assign gap_out = cur_ff.gap >= GAP_LIM;
  assign last = cur_ff.rxb[cur_ff.cnt - 4'h1];
  assign body = cur_ff.cnt - 4'h1;
  assign frame_ok = !cur_ff.ovf && cur_ff.cnt >= 4'h2 && 8'(own + cur_ff.total - last) == last;
  assign end_frame = cur_ff.state == S_COLLECT && (gap_out || (in_valid && is_addr));
  assign exec_step = cur_ff.state == S_EXEC && cur_ff.idx < body;
  assign cmd = cur_ff.rxb[cur_ff.idx];
  assign p1 = cur_ff.rxb[cur_ff.idx + 4'h1];
  assign p_word = {cur_ff.rxb[cur_ff.idx + 4'h2][3:0], p1};
  assign st_byte = {1'b0, cur_ff.sense[lpbr_pkg::SN_HOMING], cur_ff.sense[lpbr_pkg::SN_OVERHEAT],
    cur_ff.play, cur_ff.rec, cur_ff.sense[lpbr_pkg::SN_TILT_LIM], cur_ff.sense[lpbr_pkg::SN_PAN_LIM],
    cur_ff.lamp_on};
  assign wif.tx_valid = cur_ff.state == S_RESP;
  assign wif.tx_word = {1'b0, cur_ff.resp[cur_ff.tx_idx]};

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.pready = 1'b0;
    len = 4'h1;
    rd = 32'h0000_0000;
    hit = 1'b1;
    if (in_valid)
      nxt_cur.gap = 20'h00000;
    else if (!gap_out)
      nxt_cur.gap = cur_ff.gap + 20'h00001;
    if (cur_ff.hold != 23'h000000)
      nxt_cur.hold = cur_ff.hold - 23'h000001;
    else
    begin
      nxt_cur.pan_act = 1'b0;
      nxt_cur.tilt_act = 1'b0;
    end
    case (cur_ff.state)
      S_IDLE:
      begin
        nxt_cur.pend = 1'b0;
        if (in_valid && is_panel)
          nxt_cur.state = S_SLOT;
        else if (in_valid && is_addr && in_word[7:0] == own)
        begin
          nxt_cur.state = S_RESP;
          nxt_cur.tx_idx = 3'h0;
          nxt_cur.resp[0] = cur_ff.pos_pan[7:0];
          nxt_cur.resp[1] = {4'h0, cur_ff.pos_pan[11:8]};
          nxt_cur.resp[2] = cur_ff.pos_tilt[7:0];
          nxt_cur.resp[3] = {4'h0, cur_ff.pos_tilt[11:8]};
          nxt_cur.resp[4] = st_byte;
          nxt_cur.resp[5] = 8'(own + cur_ff.pos_pan[7:0] + {4'h0, cur_ff.pos_pan[11:8]}
            + cur_ff.pos_tilt[7:0] + {4'h0, cur_ff.pos_tilt[11:8]} + st_byte);
        end
      end
      S_SLOT:
      begin
        if (gap_out)
          nxt_cur.state = S_IDLE;
        else if (in_valid && in_word[7:0] == own)
        begin
          nxt_cur.state = S_COLLECT;
          nxt_cur.cnt = 4'h0;
          nxt_cur.total = 8'h00;
          nxt_cur.ovf = 1'b0;
        end
        else if (in_valid && !is_panel)
          nxt_cur.state = S_IDLE;
      end
      S_COLLECT:
      begin
        if (end_frame)
        begin
          nxt_cur.pend = in_valid && is_addr;
          nxt_cur.pend_word = in_word;
          nxt_cur.idx = 4'h0;
          if (frame_ok)
            nxt_cur.state = S_EXEC;
          else
          begin
            nxt_cur.state = S_IDLE;
            if (cur_ff.cnt != 4'h0 && cur_ff.err_cnt != 8'hFF)
              nxt_cur.err_cnt = cur_ff.err_cnt + 8'h01;
          end
        end
        else if (in_valid && cur_ff.cnt == RX_BUF)
          nxt_cur.ovf = 1'b1;
        else if (in_valid)
        begin
          nxt_cur.rxb[cur_ff.cnt] = in_word[7:0];
          nxt_cur.cnt = cur_ff.cnt + 4'h1;
          nxt_cur.total = cur_ff.total + in_word[7:0];
        end
      end
      S_EXEC:
      begin
        if (!exec_step)
          nxt_cur.state = S_IDLE;
        else
        begin
          case (cmd)
            lpbr_pkg::CMD_PAN_RATE, lpbr_pkg::CMD_TILT_RATE:
            begin
              len = 4'h2;
              if (cur_ff.idx + 4'h1 < body)
              begin
                nxt_cur.play = 1'b0;
                nxt_cur.hold = HOLD;
                if (cmd == lpbr_pkg::CMD_PAN_RATE)
                begin
                  nxt_cur.pan_rate = p1;
                  nxt_cur.pan_act = 1'b1;
                end
                else
                begin
                  nxt_cur.tilt_rate = p1;
                  nxt_cur.tilt_act = 1'b1;
                end
              end
            end
            lpbr_pkg::CMD_LAMP_TOGGLE:
              nxt_cur.lamp_on = !cur_ff.lamp_on;
            lpbr_pkg::CMD_RECORD:
              nxt_cur.rec = !cur_ff.rec;
            lpbr_pkg::CMD_PLAY:
              nxt_cur.play = !cur_ff.play;
            lpbr_pkg::CMD_STORE_HOME:
            begin
              nxt_cur.home_pan = cur_ff.pos_pan;
              nxt_cur.home_tilt = cur_ff.pos_tilt;
            end
            lpbr_pkg::CMD_PAN_TARGET, lpbr_pkg::CMD_TILT_TARGET:
            begin
              len = 4'h3;
              if (cur_ff.idx + 4'h2 < body && cmd == lpbr_pkg::CMD_PAN_TARGET)
                nxt_cur.tgt_pan = p_word;
              else if (cur_ff.idx + 4'h2 < body)
                nxt_cur.tgt_tilt = p_word;
            end
            default:
              len = 4'h1;
          endcase
          nxt_cur.idx = cur_ff.idx + len;
        end
      end
      S_RESP:
      begin
        if (wif.tx_ready && cur_ff.tx_idx == RESP_LAST)
          nxt_cur.state = S_IDLE;
        else if (wif.tx_ready)
          nxt_cur.tx_idx = cur_ff.tx_idx + 3'h1;
      end
      default:
        nxt_cur.state = S_IDLE;
    endcase

    // ****************************************
    // APB slave
    // ****************************************
    case (paddr)
      lpbr_pkg::REG_CTRL: rd = {26'h0000000, cur_ff.sw};
      lpbr_pkg::REG_POS: rd = {4'h0, cur_ff.pos_tilt, 4'h0, cur_ff.pos_pan};
      lpbr_pkg::REG_SENSE: rd = {28'h0000000, cur_ff.sense};
      lpbr_pkg::REG_STATUS: rd = {19'h00000, cur_ff.state, st_byte};
      lpbr_pkg::REG_TARGET: rd = {4'h0, cur_ff.tgt_tilt, 4'h0, cur_ff.tgt_pan};
      lpbr_pkg::REG_HOME: rd = {4'h0, cur_ff.home_tilt, 4'h0, cur_ff.home_pan};
      lpbr_pkg::REG_RATE: rd = {14'h0000, cur_ff.tilt_act, cur_ff.pan_act, cur_ff.tilt_rate, cur_ff.pan_rate};
      lpbr_pkg::REG_ERR: rd = {24'h000000, cur_ff.err_cnt};
      default: hit = 1'b0;
    endcase
    if (psel && penable && !cur_ff.pready)
    begin
      nxt_cur.pready = 1'b1;
      nxt_cur.pslverr = !hit;
      nxt_cur.prdata = pwrite ? 32'h0000_0000 : rd;
    end
    // A write lands on the edge that completes the transfer.
    if (psel && penable && cur_ff.pready && pwrite)
    begin
      if (paddr == lpbr_pkg::REG_CTRL && pwdata[5:0] <= lpbr_pkg::SW_MAX)
        nxt_cur.sw = pwdata[5:0];
      if (paddr == lpbr_pkg::REG_POS)
      begin
        nxt_cur.pos_pan = pwdata[11:0];
        nxt_cur.pos_tilt = pwdata[lpbr_pkg::HI_LSB +: 12];
      end
      if (paddr == lpbr_pkg::REG_SENSE)
        nxt_cur.sense = pwdata[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur_ff <= '0;
      cur_ff.state <= S_IDLE;
      cur_ff.sw <= lpbr_pkg::CTRL_RST;
      cur_ff.pos_pan <= lpbr_pkg::POS_CENTRE;
      cur_ff.pos_tilt <= lpbr_pkg::POS_CENTRE;
      cur_ff.tgt_pan <= lpbr_pkg::POS_CENTRE;
      cur_ff.tgt_tilt <= lpbr_pkg::POS_CENTRE;
      cur_ff.home_pan <= lpbr_pkg::POS_CENTRE;
      cur_ff.home_tilt <= lpbr_pkg::POS_CENTRE;
    end
    else
      cur_ff <= nxt_cur;
  end

  assign prdata = cur_ff.prdata;
  assign pready = cur_ff.pready;
  assign pslverr = cur_ff.pslverr;

  // ****************************************
  // Checks
  // ****************************************
  default clocking dflt @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_record_flip: assert property (exec_step && cmd == lpbr_pkg::CMD_RECORD |=> cur_ff.rec != $past(cur_ff.rec))
    else $error("Record mode did not toggle.");
  a_rate_stops_play: assert property (exec_step && cmd == lpbr_pkg::CMD_PAN_RATE && cur_ff.idx + 4'h1 < body
    |=> !cur_ff.play && cur_ff.pan_act)
    else $error("Pan rate command left playback running.");
  a_home_store: assert property (exec_step && cmd == lpbr_pkg::CMD_STORE_HOME
    |=> cur_ff.home_pan == $past(cur_ff.pos_pan) && cur_ff.home_tilt == $past(cur_ff.pos_tilt))
    else $error("Home position not stored.");
  a_buffer_limit: assert property (cur_ff.cnt <= RX_BUF)
    else $error("Receive buffer overran.");
  a_pan_target: assert property (exec_step && cmd == lpbr_pkg::CMD_PAN_TARGET && cur_ff.idx + 4'h2 < body
    |=> cur_ff.tgt_pan == $past(p_word) && cur_ff.idx == $past(cur_ff.idx) + 4'h3)
    else $error("Pan target wrongly assembled.");
  a_poll_answer: assert property (cur_ff.state == S_IDLE && in_valid && is_addr && !is_panel && in_word[7:0] == own
    |-> ##[2:3] bus_de && !bus_tx)
    else $error("Poll not answered promptly.");
  a_resp_sum: assert property ($rose(cur_ff.state == S_RESP) |-> cur_ff.resp[5] == 8'(own + cur_ff.resp[0]
    + cur_ff.resp[1] + cur_ff.resp[2] + cur_ff.resp[3] + cur_ff.resp[4]) && cur_ff.resp[1][7:4] == 4'h0)
    else $error("Answer checksum wrong.");
  a_lamp_toggle: assert property (exec_step && cmd == lpbr_pkg::CMD_LAMP_TOGGLE |=> cur_ff.lamp_on != $past(cur_ff.lamp_on))
    else $error("Lamp state not inverted.");
  a_rate_hold: assert property (cur_ff.pan_act && cur_ff.hold == 23'h000000 && !exec_step |=> !cur_ff.pan_act)
    else $error("Pan motion outlived its hold time.");
  a_addr_not_data: assert property (cur_ff.state == S_COLLECT && in_valid && is_addr
    |=> cur_ff.cnt == $past(cur_ff.cnt) && cur_ff.state != S_COLLECT)
    else $error("Address word taken as data.");
  a_bad_sum: assert property (end_frame && !frame_ok
    |=> cur_ff.state == S_IDLE && cur_ff.lamp_on == $past(cur_ff.lamp_on) && cur_ff.tgt_pan == $past(cur_ff.tgt_pan))
    else $error("Bad checksum frame acted upon.");
  a_foreign_select: assert property (cur_ff.state == S_SLOT && in_valid && in_word[7:0] != own && !gap_out
    |=> cur_ff.state != S_COLLECT)
    else $error("Foreign select word accepted.");
endmodule

// file: verif/lpbr_panel_model.sv
// Panel model: sends nine-bit words to the lamp and collects its answer.
`timescale 1ns/1ps
module lpbr_panel_model #(
  parameter int BIT_CYCLES = lpbr_pkg::BIT_CYC
)
(
  input wire logic pclk,
  input wire logic bus_tx,
  input wire logic bus_de,
  output logic bus_rx
);
  logic [8:0] got[$];
  logic [8:0] w;
  int i;
  initial bus_rx = 1'b1;
  // Start, nine data bits LSB first, stop; bit 8 marks an address.
  task automatic send_word(input logic [8:0] d);
    logic [10:0] f;
    int k;
    f = {1'b1, d, 1'b0};
    for (k = 0; k < 11; k++)
    begin
      bus_rx <= f[k];
      repeat (BIT_CYCLES) @(posedge pclk);
    end
  endtask
  // Samples each answer bit at mid period, so small drift in the lamp does not matter.
  initial forever
  begin
    @(posedge pclk);
    if (bus_de === 1'b1 && bus_tx === 1'b0)
    begin
      repeat (BIT_CYCLES / 2) @(posedge pclk);
      for (i = 0; i < 9; i++)
      begin
        repeat (BIT_CYCLES) @(posedge pclk);
        w[i] = bus_tx;
      end
      repeat (BIT_CYCLES) @(posedge pclk);
      got.push_back(w);
    end
  end
endmodule

// file: verif/lpbr_responder_tb.sv
// Self-checking bench for the lamp poll bus responder.
`timescale 1ns/1ps
module lpbr_responder_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, bus_rx, bus_tx, bus_de, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  // A short bit period keeps the serial scenarios inside the cycle budget.
  lpbr_responder #(.GAP_CYCLES(400), .RATE_HOLD_CYCLES(2000), .BIT_CYCLES(16)) u_lpbr_responder (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_rx(bus_rx), .bus_tx(bus_tx), .bus_de(bus_de));
  lpbr_panel_model #(.BIT_CYCLES(16)) u_lpbr_panel_model (.pclk(pclk), .bus_tx(bus_tx), .bus_de(bus_de),
    .bus_rx(bus_rx));
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // All scenarios need about 10000 cycles; the ceiling doubles that.
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    cmp("pready", 32'h1, {31'h0, pready});
  endtask
  task automatic t_regs();
    apb(1'b0, 12'h000, 32'h0);
    cmp("ctrl", 32'h0, q);
    apb(1'b0, 12'h020, 32'h0);
    cmp("unmapped err", 32'h1, {31'h0, e});
    apb(1'b1, 12'h004, 32'h0ABC_0123);
    apb(1'b1, 12'h008, 32'h5);
    apb(1'b0, 12'h00C, 32'h0);
    cmp("status idle", 32'h22, {24'h0, q[7:0]});
  endtask
  task automatic t_command();
    u_lpbr_panel_model.send_word(9'h100);
    u_lpbr_panel_model.send_word(9'h110);
    u_lpbr_panel_model.send_word(9'h00A);
    u_lpbr_panel_model.send_word(9'h00D);
    u_lpbr_panel_model.send_word(9'h027);
    repeat (450) @(posedge pclk);
    apb(1'b0, 12'h00C, 32'h0);
    cmp("status after cmd", 32'h2B, {24'h0, q[7:0]});
  endtask
  task automatic t_poll();
    logic [8:0] exp[6];
    int k;
    exp = '{9'h023, 9'h001, 9'h0BC, 9'h00A, 9'h02B, 9'h025};
    u_lpbr_panel_model.send_word(9'h110);
    for (k = 0; k < 2000 && u_lpbr_panel_model.got.size() < 6; k++) @(posedge pclk);
    cmp("answer count", 32'h6, u_lpbr_panel_model.got.size());
    for (k = 0; k < 6 && k < u_lpbr_panel_model.got.size(); k++)
      cmp("answer byte", {23'h0, exp[k]}, {23'h0, u_lpbr_panel_model.got[k]});
  endtask
  task automatic t_moves();
    logic [8:0] fa[11];
    logic [8:0] fb[7];
    fa = '{9'h101, 9'h110, 9'h00E, 9'h00F, 9'h018, 9'h034, 9'h007, 9'h019, 9'h056, 9'h003, 9'h0F2};
    fb = '{9'h101, 9'h110, 9'h001, 9'h0A0, 9'h002, 9'h070, 9'h023};
    foreach (fa[k]) u_lpbr_panel_model.send_word(fa[k]);
    repeat (450) @(posedge pclk);
    apb(1'b0, 12'h010, 32'h0);
    cmp("target", 32'h0356_0734, q);
    apb(1'b0, 12'h014, 32'h0);
    cmp("home", 32'h0ABC_0123, q);
    apb(1'b0, 12'h00C, 32'h0);
    cmp("status playing", 32'h3B, {24'h0, q[7:0]});
    foreach (fb[k]) u_lpbr_panel_model.send_word(fb[k]);
    repeat (450) @(posedge pclk);
    apb(1'b0, 12'h018, 32'h0);
    cmp("rate active", 32'h0003_70A0, q);
    apb(1'b0, 12'h00C, 32'h0);
    cmp("status play stopped", 32'h2B, {24'h0, q[7:0]});
    repeat (2000) @(posedge pclk);
    apb(1'b0, 12'h018, 32'h0);
    cmp("rate expired", 32'h0000_70A0, q);
  endtask
  task automatic t_bad_frame();
    logic [8:0] fc[4];
    fc = '{9'h102, 9'h110, 9'h00A, 9'h055};
    foreach (fc[k]) u_lpbr_panel_model.send_word(fc[k]);
    repeat (450) @(posedge pclk);
    apb(1'b0, 12'h01C, 32'h0);
    cmp("error count", 32'h1, q);
    apb(1'b0, 12'h00C, 32'h0);
    cmp("status kept", 32'h2B, {24'h0, q[7:0]});
  endtask
  task automatic t_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h00C, 32'h0);
    cmp("status after reset", 32'h0000_0100, q);
    apb(1'b0, 12'h010, 32'h0);
    cmp("target after reset", 32'h0800_0800, q);
    apb(1'b1, 12'h000, 32'h29);
    apb(1'b0, 12'h000, 32'h0);
    cmp("switch too high", 32'h0, q);
    apb(1'b1, 12'h000, 32'h28);
    apb(1'b0, 12'h000, 32'h0);
    cmp("switch top", 32'h28, q);
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_command();
    t_poll();
    t_moves();
    t_bad_frame();
    t_reset();
    wrap_up();
  end
endmodule
